// [inc/lpr_pkg.sv]
// package for the led pwm ramp blink controller: map, fields, timing
package lpr_pkg;
  // ==========================================================
  // register map (word index on the plain register port)
  localparam logic [3:0] REG_MAIN_OFS  = 4'h0;  // main display backlight channel
  localparam logic [3:0] REG_AUX_OFS   = 4'h1;  // aux display backlight channel
  localparam logic [3:0] REG_KEY_OFS   = 4'h2;  // keypad backlight channel
  localparam logic [3:0] REG_RED_OFS   = 4'h3;  // red signal channel
  localparam logic [3:0] REG_GRN_OFS   = 4'h4;  // green signal channel
  localparam logic [3:0] REG_BLU_OFS   = 4'h5;  // blue signal channel
  localparam logic [3:0] REG_BOOST_OFS = 4'h6;  // boost requests
  localparam logic [3:0] REG_STAT_OFS  = 4'h7;  // effective duty / drive status
  // ==========================================================
  // channel register fields
  localparam int DUTY_LSB    = 0;   // duty_code [5:0]
  localparam int CUR_LSB     = 6;   // sink_current_code [8:6]
  localparam int RAMP_BIT    = 9;   // ramp_select
  localparam int HI_BIT      = 10;  // high_range_select (backlight)
  localparam int PER_LSB     = 11;  // blink_period_code [12:11] (signal)
  localparam int PP_BIT      = 13;  // push-pull pwm mode (signal)
  localparam int GEN_BIT     = 0;   // general_boost_request
  localparam int USB_BIT     = 1;   // usb_boost_request
  localparam int LED_BIT     = 2;   // led_boost_request
  localparam logic [15:0] CHAN_RST = 16'h0000;  // all channels off after reset
  // ==========================================================
  // timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int SLOT_HZ     = 256 * 32;               // 32 slots per 1/256 s
  localparam int SLOT_CYC    = CLK_HZ / SLOT_HZ;       // cycles per pwm slot
  localparam int RAMP_HZ     = 64;                     // one step every 1/64 s
  localparam int RAMP_CYC    = CLK_HZ / RAMP_HZ;       // cycles per ramp tick
  localparam int SHARE_SLOTS = 1;                      // share toggle per slot
  // blink period in base periods (1/256 s units): 1/256, 1/8, 1, 2 s
  localparam logic [9:0] PER_MULT [4] = '{10'h001, 10'h020, 10'h100, 10'h200};
  // channel settings carrier
  typedef struct packed {
    logic       push_pull;
    logic [1:0] period;
    logic       high;
    logic       ramp;
    logic [2:0] current;
    logic [5:0] duty;
  } lpr_chan_t;
endpackage

// [design/lpr_ramp.sv]
// one channel's duty tracker: immediate or stepped toward target
`timescale 1ns/1ns
module lpr_ramp
  import lpr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       load,      // new duty written
  input  wire logic [5:0] target,    // written duty code
  input  wire logic       ramp_en,   // ramp selected and allowed
  input  wire logic       tick,      // 1/64 s step strobe
  // result
  output logic      [5:0] eff        // effective duty 0..32
);
  // codes at or above 32 mean fully on: clamp to 32
  function automatic logic [5:0] clamp32(input logic [5:0] c);
    return c[5] ? 6'h20 : c;
  endfunction

  logic [5:0] eff_reg, eff_next;  // effective duty
  logic [5:0] tgt_reg, tgt_next;  // ramp target
  logic       act_reg, act_next;  // ramp running

  // ==========================================================
  // next state
  always_comb begin
    eff_next = eff_reg;
    tgt_next = tgt_reg;
    act_next = act_reg;
    if (load) begin
      tgt_next = clamp32(target);
      if (ramp_en) begin
        act_next = 1'b1;
      end else begin
        eff_next = clamp32(target);
        act_next = 1'b0;
      end
    end else if (act_reg && !ramp_en) begin
      eff_next = tgt_reg;                      // blink forbids ramping: jump
      act_next = 1'b0;
    end else if (act_reg && tick) begin
      if (eff_reg < tgt_reg) begin
        eff_next = eff_reg + 6'h01;
      end else if (eff_reg > tgt_reg) begin
        eff_next = eff_reg - 6'h01;
      end else begin
        act_next = 1'b0;
      end
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      eff_reg <= 6'h00;
      tgt_reg <= 6'h00;
      act_reg <= 1'b0;
    end else begin
      eff_reg <= eff_next;
      tgt_reg <= tgt_next;
      act_reg <= act_next;
    end
  end
  assign eff = eff_reg;

  // one step per tick at most
  property p_step;
    @(posedge clk) disable iff (rst)
      !load && !tick |=> (eff_reg == $past(eff_reg)) || !$past(act_reg) || $past(!ramp_en);
  endproperty
  a_step: assert property (p_step) else $error("duty moved without tick");
  // step size is one
  property p_size;
    @(posedge clk) disable iff (rst)
      !load && act_reg && ramp_en && tick |=>
        (eff_reg == $past(eff_reg) + 6'h01) || (eff_reg == $past(eff_reg) - 6'h01)
        || (eff_reg == $past(eff_reg));
  endproperty
  a_size: assert property (p_size) else $error("ramp step not one");
  // immediate load without ramp
  property p_imm;
    @(posedge clk) disable iff (rst)
      load && !ramp_en |=> eff_reg == ($past(target[5]) ? 6'h20 : $past(target));
  endproperty
  a_imm: assert property (p_imm) else $error("direct load not applied");
  // hold at target
  property p_hold;
    @(posedge clk) disable iff (rst)
      !act_reg && !load |=> eff_reg == $past(eff_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("duty moved after ramp end");
endmodule // lpr_ramp

// [design/lpr_top.sv]
// led pwm controller top: registers, timebase, sharing, blink, outputs
`timescale 1ns/1ns
// Contract
// - ramp one step per 1/64 s tick
// - duty write with ramp bit starts ramp
// - without ramp bit duty applies at once
// - backlight enabled when duty not zero
// - three backlights enabled: none driven
// - two backlights alternate with equal shares
// - shared backlights get doubled current
// - period code picks 1/256,1/8,1,2 s
// - blinking channel never ramps
// - signal duty code/32; top bit on
// - signal current 3 mA steps to 21
// - boost enable ORs three requests
// - signal pins open drain or pwm
// - high range doubles backlight current step
// - backlight duty code/32; 32+ always on
module lpr_top
  import lpr_pkg::*;
#(
  parameter int RAMP_CYCLES = RAMP_CYC,  // cycles per 1/64 s, shorten for sim
  parameter int SLOT_CYCLES = SLOT_CYC   // cycles per pwm slot
)(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // backlight sinks: on flag and current in 3 mA units (0..28)
  output logic      [2:0]  BL_ON,
  output logic      [14:0] BL_CURRENT,
  // signal sinks: on flag, current in 3 mA units, pin drive
  output logic      [2:0]  SIG_ON,
  output logic      [8:0]  SIG_CURRENT,
  output logic      [2:0]  SIG_OUT,
  output logic      [2:0]  SIG_OE,
  // boost supply enable
  output logic             BOOST_EN
);
  // counters are 24 and 16 bits wide: refuse counts they cannot reach
  if (RAMP_CYCLES < 1 || RAMP_CYCLES > 16777216 ||
      SLOT_CYCLES < 1 || SLOT_CYCLES > 65536) begin : g_bad_count
    $error("cycle counts out of range");
  end

  // ==========================================================
  // register file
  lpr_chan_t  chan_reg [6];        // six channel settings
  lpr_chan_t  chan_next [6];
  logic [2:0] boost_reg, boost_next;   // boost request bits
  logic [15:0] rdata_reg, rdata_next;  // read data
  logic [5:0] load;                    // duty write per channel
  logic [5:0] eff [6];                 // effective duty per channel

  function automatic logic [15:0] chan_word(input lpr_chan_t c);
    return {2'b00, c};
  endfunction

  // decode writes and reads
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      chan_next[i] = chan_reg[i];
      load[i]      = 1'b0;
    end
    boost_next = boost_reg;
    rdata_next = 16'h0000;
    if (WR) begin
      if (ADDR <= REG_BLU_OFS) begin
        chan_next[ADDR[2:0]] = lpr_chan_t'(WDATA[13:0]);
        load[ADDR[2:0]]      = 1'b1;            // every write reloads duty
      end else if (ADDR == REG_BOOST_OFS) begin
        boost_next = WDATA[2:0];
      end
    end
    if (RD) begin
      if (ADDR <= REG_BLU_OFS) begin
        rdata_next = chan_word(chan_reg[ADDR[2:0]]);
      end else if (ADDR == REG_BOOST_OFS) begin
        rdata_next = {13'h0000, boost_reg};
      end else if (ADDR == REG_STAT_OFS) begin
        rdata_next = {4'h0, SIG_ON, BL_ON, eff[0]};  // live state
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < 6; i++) chan_reg[i] <= lpr_chan_t'(CHAN_RST[13:0]);
      boost_reg <= 3'h0;
      rdata_reg <= 16'h0000;
    end else begin
      for (int i = 0; i < 6; i++) chan_reg[i] <= chan_next[i];
      boost_reg <= boost_next;
      rdata_reg <= rdata_next;
    end
  end
  assign RDATA = rdata_reg;

  // ==========================================================
  // timebase: slot strobe, 32-slot phase, base-period count, ramp tick
  logic [15:0] slot_cnt_reg, slot_cnt_next;
  logic [4:0]  phase_reg, phase_next;     // slot within period
  logic [9:0]  base_reg, base_next;       // base periods elapsed
  logic [23:0] tick_cnt_reg, tick_cnt_next;
  logic        share_reg, share_next;     // which backlight owns the boost
  logic        slot_stb, tick;

  always_comb begin
    slot_stb      = (slot_cnt_reg == 16'(SLOT_CYCLES - 1));
    tick          = (tick_cnt_reg == 24'(RAMP_CYCLES - 1));
    slot_cnt_next = slot_stb ? 16'h0000 : slot_cnt_reg + 16'h0001;
    tick_cnt_next = tick ? 24'h000000 : tick_cnt_reg + 24'h000001;
    phase_next    = phase_reg;
    base_next     = base_reg;
    share_next    = share_reg;
    if (slot_stb) begin
      phase_next = phase_reg + 5'h01;
      share_next = ~share_reg;
      if (phase_reg == 5'h1F) base_next = base_reg + 10'h001;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      slot_cnt_reg <= 16'h0000;
      tick_cnt_reg <= 24'h000000;
      phase_reg    <= 5'h00;
      base_reg     <= 10'h000;
      share_reg    <= 1'b0;
    end else begin
      slot_cnt_reg <= slot_cnt_next;
      tick_cnt_reg <= tick_cnt_next;
      phase_reg    <= phase_next;
      base_reg     <= base_next;
      share_reg    <= share_next;
    end
  end

  // ==========================================================
  // per-channel duty trackers
  for (genvar g = 0; g < 6; g++) begin : g_ramp
    logic ramp_ok;
    // signal channels ramp only when not blinking
    // new settings count in the write cycle itself, so the load sees them
    assign ramp_ok = chan_next[g].ramp && (g < 3 || chan_next[g].period == 2'b00);
    lpr_ramp u_ramp (
      .clk    (CORE_CLK),
      .rst    (RST),
      .load   (load[g]),
      .target (chan_next[g].duty),
      .ramp_en(ramp_ok),
      .tick   (tick),
      .eff    (eff[g])
    );
  end

  // ==========================================================
  // output stage
  logic [2:0]  bl_en;
  logic [2:0]  bl_on_next, sig_on_next, sig_out_next, sig_oe_next;
  logic [14:0] bl_cur_next;
  logic [8:0]  sig_cur_next;
  logic [2:0]  bl_on_reg, sig_on_reg, sig_out_reg, sig_oe_reg;
  logic [14:0] bl_cur_reg;
  logic [8:0]  sig_cur_reg;
  logic        boost_en_reg, boost_en_next;  // boost supply enable
  logic [1:0]  n_en;
  logic        pwm;
  logic [15:0] blink_pos;  // slot index within blink period
  logic [15:0] blink_len;

  always_comb begin
    bl_on_next   = 3'h0;
    bl_cur_next  = 15'h0000;
    sig_on_next  = 3'h0;
    sig_cur_next = 9'h000;
    sig_out_next = 3'h0;
    sig_oe_next  = 3'h0;
    blink_pos    = 16'h0000;
    blink_len    = 16'h0000;
    pwm          = 1'b0;
    boost_en_next = boost_reg[GEN_BIT] | boost_reg[USB_BIT] | boost_reg[LED_BIT];
    for (int i = 0; i < 3; i++) bl_en[i] = (eff[i] != 6'h00);
    n_en = 2'(bl_en[0]) + 2'(bl_en[1]) + 2'(bl_en[2]);
    for (int i = 0; i < 3; i++) begin
      // fully on at 32, else on for eff slots out of 32
      pwm = eff[i][5] || ({1'b0, phase_reg} < eff[i]);
      if (n_en == 2'd3) begin
        pwm = 1'b0;
      end else if (n_en == 2'd2) begin
        // owner is the lower-index enabled channel when share is 0
        pwm = pwm && bl_en[i] &&
              ((share_reg == 1'b0) == (i == 0 || (i == 1 && !bl_en[0])));
      end
      bl_on_next[i] = pwm;
      // step 1 unit low range, 2 units high range; doubled when shared
      bl_cur_next[i*5 +: 5] = 5'({2'b00, chan_reg[i].current}
                              << (32'(chan_reg[i].high) + 32'(n_en == 2'd2)));
    end
    for (int i = 0; i < 3; i++) begin
      // blink period is PER_MULT base periods, each 32 slots
      blink_len = 16'({PER_MULT[chan_reg[3+i].period], 5'h00});
      blink_pos = 16'({base_reg, phase_reg}) % blink_len;
      // duty spans code/32 of the whole period
      pwm = eff[3+i][5] ||
            (blink_pos < 16'(32'(eff[3+i]) * 32'(PER_MULT[chan_reg[3+i].period])));
      sig_on_next[i]        = pwm;
      sig_cur_next[i*3 +: 3] = chan_reg[3+i].current;
      // open drain pulls low when on; push-pull drives the pwm level
      sig_out_next[i] = chan_reg[3+i].push_pull ? pwm : 1'b0;
      sig_oe_next[i]  = chan_reg[3+i].push_pull ? 1'b1 : pwm;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bl_on_reg   <= 3'h0;
      bl_cur_reg  <= 15'h0000;
      sig_on_reg  <= 3'h0;
      sig_cur_reg <= 9'h000;
      sig_out_reg <= 3'h0;
      sig_oe_reg  <= 3'h0;
      boost_en_reg <= 1'b0;
    end else begin
      bl_on_reg   <= bl_on_next;
      bl_cur_reg  <= bl_cur_next;
      sig_on_reg  <= sig_on_next;
      sig_cur_reg <= sig_cur_next;
      sig_out_reg <= sig_out_next;
      sig_oe_reg  <= sig_oe_next;
      boost_en_reg <= boost_en_next;
    end
  end
  assign BL_ON       = bl_on_reg;
  assign BL_CURRENT  = bl_cur_reg;
  assign SIG_ON      = sig_on_reg;
  assign SIG_CURRENT = sig_cur_reg;
  assign SIG_OUT     = sig_out_reg;
  assign SIG_OE      = sig_oe_reg;
  assign BOOST_EN    = boost_en_reg;

  // ==========================================================
  // checks
  property p_three;
    @(posedge CORE_CLK) disable iff (RST)
      (eff[0] != 6'h00 && eff[1] != 6'h00 && eff[2] != 6'h00) |=> BL_ON == 3'h0;
  endproperty
  a_three: assert property (p_three) else $error("three backlights driven");
  property p_share;
    @(posedge CORE_CLK) disable iff (RST)
      $countones(BL_ON) <= 1 || $countones(bl_en) < 2;
  endproperty
  a_share: assert property (p_share) else $error("two backlights on together");
  property p_boost;
    @(posedge CORE_CLK) disable iff (RST)
      ##1 BOOST_EN == $past(|boost_reg);
  endproperty
  a_boost: assert property (p_boost) else $error("boost enable mismatch");
  property p_sigoff;
    @(posedge CORE_CLK) disable iff (RST)
      eff[3] == 6'h00 |=> !SIG_ON[0];
  endproperty
  a_sigoff: assert property (p_sigoff) else $error("signal on at zero duty");
endmodule // lpr_top

// [sim/lpr_led_model.sv]
// led strings and shared boost supply on the far side of the sinks
`timescale 1ns/1ns
module lpr_led_model
  import lpr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // sink and pin drive from the controller
  input  wire logic [2:0] bl_on,
  input  wire logic [2:0] sig_out,
  input  wire logic [2:0] sig_oe,
  // observed levels
  output logic      [2:0] sig_pin,   // pin level with external pull-up
  output int              overload   // cycles with two strings on the boost
);
  // ==========================================
  // pins
  // a released open-drain pin floats up through the pull-up
  assign sig_pin = (sig_oe & sig_out) | ~sig_oe;
  // ==========================================
  // boost supply
  // the shared boost output feeds one string at a time, so any overlap is counted
  always_ff @(posedge clk) begin
    if (rst) begin
      overload <= 0;
    end else if ($countones(bl_on) > 1) begin
      overload <= overload + 1;
    end
  end
endmodule // lpr_led_model

// [sim/tb_lpr_top.sv]
// self-checking bench for the led pwm controller top
`timescale 1ns/1ns
module tb_lpr_top;
  import lpr_pkg::*;
  // ==========================================
  // short counts keep the run small
  localparam int RC = 8;        // cycles per ramp tick
  localparam int SC = 2;        // cycles per pwm slot
  localparam int PB = 32 * SC;  // base pwm period in cycles
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [3:0]  addr     = 4'h0;
  logic [15:0] wdata    = 16'h0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [15:0] rdata;
  logic [2:0]  bl_on, sig_on, sig_out, sig_oe, sig_pin;
  logic [14:0] bl_current;
  logic [8:0]  sig_current;
  logic        boost_en;
  int          overload;
  int          failures    = 0;
  int          checks_done = 0;
  int          on_cnt [8];  // 0..2 backlight, 3..5 signal, 6 red pin high, 7 red oe
  int          mult [4]    = '{1, 32, 256, 512};
  logic [15:0] d, r;
  logic [5:0]  codes [6] = '{6'h00, 6'h01, 6'h10, 6'h1F, 6'h20, 6'h3F};  // duty codes tried
  int          prev, first, last, n;
  // ==========================================
  // design and far side
  lpr_top #(.RAMP_CYCLES(RC), .SLOT_CYCLES(SC)) lpr_top_inst (
    .CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .BL_ON(bl_on), .BL_CURRENT(bl_current), .SIG_ON(sig_on),
    .SIG_CURRENT(sig_current), .SIG_OUT(sig_out), .SIG_OE(sig_oe), .BOOST_EN(boost_en));
  lpr_led_model lpr_led_model_inst (
    .clk(core_clk), .rst(rst), .bl_on(bl_on), .sig_out(sig_out), .sig_oe(sig_oe),
    .sig_pin(sig_pin), .overload(overload));
  // 25 mhz clock
  always #20 core_clk = ~core_clk;
  // ==========================================
  // tasks
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  // one-cycle write strobe
  task automatic wrt(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdt(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // on-cycle counts over a window, phase free for whole periods
  task automatic cnt(input int c);
    on_cnt = '{default: 0};
    repeat (c) begin
      @(posedge core_clk);
      #1;
      for (int i = 0; i < 3; i++) begin
        on_cnt[i]     += (bl_on[i] === 1'b1);
        on_cnt[3 + i] += (sig_on[i] === 1'b1);
      end
      on_cnt[6] += (sig_pin[0] === 1'b1);
      on_cnt[7] += (sig_oe[0] === 1'b1);
    end
  endtask
  function automatic logic [15:0] ch(logic pp, logic [1:0] per, logic hi, logic rm,
                                     logic [2:0] cur, logic [5:0] dc);
    lpr_chan_t c;
    c = '{push_pull: pp, period: per, high: hi, ramp: rm, current: cur, duty: dc};
    return {2'h0, c};
  endfunction
  // write a ramped duty and follow the effective duty one step at a time
  task automatic ramp_to(input logic [5:0] tgt);
    wrt(REG_MAIN_OFS, ch(1'b0, 2'h0, 1'b0, 1'b1, 3'h1, tgt));
    n = (tgt > prev) ? tgt - prev : prev - tgt;
    first = -1;
    for (int k = 0; k < n * RC / 2 + 2 * RC; k++) begin
      rdt(REG_STAT_OFS, d);
      if (d[5:0] !== prev[5:0]) begin
        chk(d[5:0], (tgt > prev) ? prev + 1 : prev - 1);
        prev = d[5:0];
        last = k;
        if (first < 0) first = k;
      end
    end
    chk(prev, tgt);
    chk((last - first) * 2 / RC, n - 1);
  endtask
  // ==========================================
  // watchdog
  initial begin
    // the tests need about 53000 cycles; stay under the run budget
    #(90000 * 40);
    failures++;
    stop_test();
  end
  // ==========================================
  // main sequence
  initial begin
    wt(4);
    rst <= 1'b0;
    wt(1);
    chk({boost_en, bl_on, sig_on}, 16'h0000);
    // backlight duty codes incl. zero and the always-on range
    foreach (codes[j]) begin
      d = {10'h000, codes[j]};
      wrt(REG_MAIN_OFS, ch(1'b0, 2'h0, 1'b0, 1'b0, 3'h4, d[5:0]));
      rdt(REG_STAT_OFS, r);
      chk(r[5:0], (d > 32) ? 32 : d);
      wt(3);
      cnt(PB);
      chk(on_cnt[0], ((d > 32) ? 32 : d) * SC);
    end
    chk(bl_current[4:0], 5'h04);
    wrt(REG_MAIN_OFS, ch(1'b0, 2'h0, 1'b1, 1'b0, 3'h5, 6'h20));
    wt(3);
    chk(bl_current[4:0], 5'h0A);
    // two backlights share the boost
    wrt(REG_KEY_OFS, ch(1'b0, 2'h0, 1'b0, 1'b0, 3'h3, 6'h20));
    wt(4);
    cnt(PB);
    chk(on_cnt[0], PB / 2);
    chk(on_cnt[2], PB / 2);
    chk(overload, 0);
    chk({bl_current[14:10], bl_current[4:0]}, {5'h06, 5'h14});
    // a third one switches all of them off
    wrt(REG_AUX_OFS, ch(1'b0, 2'h0, 1'b0, 1'b0, 3'h1, 6'h01));
    wt(4);
    cnt(PB);
    chk(on_cnt[0] + on_cnt[1] + on_cnt[2], 0);
    chk(bl_current[9:5], 5'h01);
    wrt(REG_AUX_OFS, 16'h0000);
    wrt(REG_KEY_OFS, 16'h0000);
    // ramps up and down, then an immediate change
    wrt(REG_MAIN_OFS, 16'h0000);
    prev = 0;
    ramp_to(6'h08);
    ramp_to(6'h02);
    wrt(REG_MAIN_OFS, ch(1'b0, 2'h0, 1'b0, 1'b0, 3'h1, 6'h14));
    rdt(REG_STAT_OFS, d);
    chk(d[5:0], 6'h14);
    // red blink periods, open drain
    for (int p = 0; p < 4; p++) begin
      wrt(REG_RED_OFS, ch(1'b0, p[1:0], 1'b0, 1'b0, 3'h7, 6'h08));
      wt(3);
      cnt(PB * mult[p]);
      chk(on_cnt[3], 8 * SC * mult[p]);
      chk(on_cnt[7], on_cnt[3]);
      chk(on_cnt[6], PB * mult[p] - on_cnt[3]);
    end
    chk(sig_current[2:0], 3'h7);
    // push-pull pwm output
    wrt(REG_RED_OFS, ch(1'b1, 2'h0, 1'b0, 1'b0, 3'h2, 6'h08));
    wt(3);
    cnt(PB);
    chk(on_cnt[7], PB);
    chk(on_cnt[6], 8 * SC);
    rdt(REG_RED_OFS, d);
    chk(d, ch(1'b1, 2'h0, 1'b0, 1'b0, 3'h2, 6'h08));
    // colour mix by current code: off, top bit on, sink level follows the code
    for (int j = 0; j < 3; j++) begin
      wrt(REG_GRN_OFS, ch(1'b0, 2'h0, 1'b0, 1'b0, j[2:0] * 3'h3, (j == 2) ? 6'h2A : 6'h00));
      wt(3);
      cnt(PB);
      chk(on_cnt[4], (j == 2) ? PB : 0);
      chk(sig_current[5:3], j[2:0] * 3'h3);
    end
    // blinking blue channel must not ramp up from zero
    wrt(REG_BLU_OFS, ch(1'b0, 2'h1, 1'b0, 1'b1, 3'h1, 6'h20));
    wt(3);
    chk(sig_on[2], 1'b1);
    chk(sig_current[8:6], 3'h1);
    // boost request combinations
    for (int b = 0; b < 8; b++) begin
      wrt(REG_BOOST_OFS, {13'h0000, b[2:0]});
      wt(2);
      chk(boost_en, |b[2:0]);
    end
    // unmapped place
    wrt(4'hF, 16'hFFFF);
    rdt(4'hF, d);
    chk(d, 16'h0000);
    stop_test();
  end
endmodule // tb_lpr_top
